/* rtl/idlcmd_consts.svh */
/*
 offsets, field positions, reset values, codes and timing counts of the
 idle / standby timer command block; assumes inclusion by bare name.
*/
`ifndef IDLCMD_CONSTS_SVH
`define IDLCMD_CONSTS_SVH

// register word indexes (byte address = index * 4)
`define IDLCMD_OFS_CMD 6'h00
`define IDLCMD_OFS_SECCNT 6'h01
`define IDLCMD_OFS_DEVHEAD 6'h02
`define IDLCMD_OFS_STATUS 6'h03
`define IDLCMD_OFS_ERROR 6'h04
`define IDLCMD_OFS_GEOM 6'h05
`define IDLCMD_OFS_CTRL 6'h06
`define IDLCMD_OFS_IRQ_STAT 6'h07
`define IDLCMD_OFS_IRQ_MASK 6'h08
`define IDLCMD_OFS_PMODE 6'h09

// opcodes
`define IDLCMD_OP_IDLE_A 8'he3
`define IDLCMD_OP_IDLE_B 8'h97
`define IDLCMD_OP_IMM_A 8'he1
`define IDLCMD_OP_IMM_B 8'h95
`define IDLCMD_OP_INIT 8'h91

// timeout codes and their intervals in seconds
`define IDLCMD_TO_LIN_MAX 8'hf0
`define IDLCMD_TO_HALF_MAX 8'hfb
`define IDLCMD_TO_C252 8'hfc
`define IDLCMD_TO_C253 8'hfd
`define IDLCMD_TO_C254 8'hfe
`define IDLCMD_TO_LIN_BASE 15'h00f0
`define IDLCMD_TO_LIN_SEC 15'h0005
`define IDLCMD_TO_HALF_SEC 15'h0708
`define IDLCMD_TO_S252 15'h04ec
`define IDLCMD_TO_S253 15'h7080
`define IDLCMD_TO_S255 15'h04fb

// field positions
`define IDLCMD_CTRL_SRST 0
`define IDLCMD_CTRL_REVERT 1
`define IDLCMD_EV_DONE 0
`define IDLCMD_EV_STBY 1
`define IDLCMD_EV_ABORT 2
`define IDLCMD_ERR_ABT 2
`define IDLCMD_HSIZE_WORD 3'h2

// reset values of geometry
`define IDLCMD_RST_SPT 8'h3f
`define IDLCMD_RST_HEADS_M1 4'hf

// timer tick: one second at a 10 ns clock
`define IDLCMD_CLK_NS 10
`define IDLCMD_TICK_NS 1000000000
`define IDLCMD_TICK_CYC (`IDLCMD_TICK_NS / `IDLCMD_CLK_NS)

`endif

/* rtl/idlcmd_pkg.sv */
/*
 types of the idle / standby timer command block; assumes the consts
 header for all numbers.
*/
package idlcmd_pkg;

    typedef enum logic {CS_READY, CS_SPIN} idlcmd_cs_t;

    typedef struct packed {
        logic ph_wr;
        logic ph_rd;
        logic [5:0] ph_addr;
        logic hready;
        logic [31:0] hrdata;
        logic sync1;
        logic sync2;
        idlcmd_cs_t cs;
        logic [7:0] seccnt;
        logic [7:0] devhead;
        logic err_abt;
        logic idle;
        logic standby;
        logic spin_up;
        logic [7:0] spt;
        logic [3:0] heads_m1;
        logic revert_en;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic t_load;
        logic [14:0] t_secs;
        logic t_apd;
        logic t_access;
    } idlcmd_st_t;

    typedef struct packed {
        logic [31:0] pre;
        logic [14:0] left;
        logic [14:0] prog;
        logic prog_en;
        logic en;
        logic fire;
    } idlcmd_tst_t;

endpackage

/* rtl/idlcmd_tmr_if.sv */
/*
 carrier between the command block and its standby countdown;
 assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface idlcmd_tmr_if;
    logic load;
    logic [14:0] secs;
    logic apd_en;
    logic access;
    logic run;
    logic expired;
    modport ctl (output load, output secs, output apd_en, output access, output run,
        input expired);
    modport tmr (input load, input secs, input apd_en, input access, input run,
        output expired);
endinterface

/* rtl/idlcmd_decode.sv */
/*
 decodes the timeout code into seconds; purely combinational,
 assumes the code is stable while used.
*/
`timescale 1ns/10ps
`include "idlcmd_consts.svh"
module idlcmd_decode (
    // timeout code
    input wire logic [7:0] code,
    // decoded interval
    output logic [14:0] secs,
    output logic apd_en,
    output logic abort
);
    always_comb begin
        secs = 15'h0000;
        apd_en = 1'b0;
        abort = 1'b0;
        if (code == 8'h00) begin
            apd_en = 1'b0; // RQ3
        end else if (code <= `IDLCMD_TO_LIN_MAX) begin
            secs = {7'h00, code} * `IDLCMD_TO_LIN_SEC; // RQ4
            apd_en = 1'b1; // RQ3
        end else if (code <= `IDLCMD_TO_HALF_MAX) begin
            secs = ({7'h00, code} - `IDLCMD_TO_LIN_BASE) * `IDLCMD_TO_HALF_SEC; // RQ4
            apd_en = 1'b1;
        end else if (code == `IDLCMD_TO_C252) begin
            secs = `IDLCMD_TO_S252; // RQ5
            apd_en = 1'b1;
        end else if (code == `IDLCMD_TO_C253) begin
            secs = `IDLCMD_TO_S253; // RQ5
            apd_en = 1'b1;
        end else if (code == `IDLCMD_TO_C254) begin
            abort = 1'b1; // RQ5
        end else begin
            secs = `IDLCMD_TO_S255; // RQ5
            apd_en = 1'b1;
        end
    end
endmodule

/* rtl/idlcmd_timer.sv */
/*
 standby countdown in whole seconds; assumes load and access are
 one-cycle pulses from the command block on the same clock.
*/
`timescale 1ns/10ps
`include "idlcmd_consts.svh"
module idlcmd_timer #(
    parameter int unsigned TICK_CYC = `IDLCMD_TICK_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    idlcmd_tmr_if.tmr tif
);
    idlcmd_pkg::idlcmd_tst_t s_r;
    idlcmd_pkg::idlcmd_tst_t s_nxt;

    assign tif.expired = s_r.fire;

    always_comb begin
        s_nxt = s_r;
        s_nxt.fire = 1'b0;
        if (tif.load) begin
            s_nxt.prog = tif.secs; // RQ1
            s_nxt.prog_en = tif.apd_en; // RQ3
            s_nxt.en = tif.apd_en;
            s_nxt.left = tif.secs;
            s_nxt.pre = 32'h0000_0000;
        end else if (tif.access) begin
            // any host access restarts the full interval and re-arms
            s_nxt.left = s_r.prog; // RQ7
            s_nxt.en = s_r.prog_en;
            s_nxt.pre = 32'h0000_0000;
        end else if (s_r.en && tif.run) begin
            if (s_r.pre >= TICK_CYC - 1) begin
                s_nxt.pre = 32'h0000_0000;
                if (s_r.left <= 15'h0001) begin
                    s_nxt.left = 15'h0000;
                    s_nxt.fire = 1'b1; // RQ6
                    s_nxt.en = 1'b0;
                end else begin
                    s_nxt.left = s_r.left - 15'h0001; // RQ1
                end
            end else begin
                s_nxt.pre = s_r.pre + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* rtl/idlcmd_top.sv */
/*
 idle / idle immediate / initialize device parameters command block
 behind an ahb-lite slave. assumes a single ahb master with this slave
 alone on the bus, and a spindle speed indication from the motor logic.
*/
// The AHB-Lite register port and the placing of the registers were left to the implementer.
// Contract
// RQ1 - idle opcode: enter idle, load timer, count
// RQ2 - spin up only when spindle not turning
// RQ3 - timeout code zero disables power-down
// RQ4 - codes 1-240 x5 s, 241-251 x30 min
// RQ5 - 252/253/255 special intervals, 254 aborts
// RQ6 - timer expiry without access enters standby
// RQ7 - host access reloads full interval
// RQ8 - idle keeps spindle turning, no delay
// RQ9 - idle immediate enters idle, conditional spin-up
// RQ10 - idle immediate keeps programmed timeout
// RQ11 - init params: sectors per track, heads minus one
// RQ12 - geometry readable as identify words
// RQ13 - geometry kept until init, power, revert reset
// RQ14 - zero sectors per track means zero
// RQ15 - host gives heads minus one 0-15
// RQ16 - host keeps cylinders within ffffh
// RQ17 - completion clears busy, fault; abort sets abt, err
`timescale 1ns/10ps
`include "idlcmd_consts.svh"
module idlcmd_top #(
    parameter int unsigned TICK_CYC = `IDLCMD_TICK_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // spindle
    input wire logic spindle_at_speed,
    output logic spin_up_req,
    // power state
    output logic idle_mode,
    output logic standby_mode,
    // interrupt
    output logic irq
);
    idlcmd_pkg::idlcmd_st_t s_r;
    idlcmd_pkg::idlcmd_st_t s_nxt;
    idlcmd_tmr_if tif ();
    logic [14:0] dec_secs;
    logic dec_apd;
    logic dec_abort;

    idlcmd_decode u_decode (
        .code(s_r.seccnt),
        .secs(dec_secs),
        .apd_en(dec_apd),
        .abort(dec_abort)
    );

    idlcmd_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .tif(tif)
    );

    assign tif.load = s_r.t_load;
    assign tif.secs = s_r.t_secs;
    assign tif.apd_en = s_r.t_apd;
    assign tif.access = s_r.t_access;
    // the countdown only runs once the command has finished
    assign tif.run = s_r.idle && (s_r.cs == idlcmd_pkg::CS_READY);

    assign hreadyout = s_r.hready;
    assign hrdata = s_r.hrdata;
    assign hresp = 1'b0;
    assign spin_up_req = s_r.spin_up;
    assign idle_mode = s_r.idle;
    assign standby_mode = s_r.standby;
    assign irq = s_r.irq;

    function automatic logic [31:0] rd_val(input idlcmd_pkg::idlcmd_st_t s,
        input logic [5:0] a);
        logic bsy;
        logic [4:0] heads;
        bsy = (s.cs == idlcmd_pkg::CS_SPIN);
        heads = {1'b0, s.heads_m1} + 5'h01;
        rd_val = 32'h0000_0000;
        case (a)
            `IDLCMD_OFS_SECCNT: begin
                rd_val = {24'h000000, s.seccnt};
            end
            `IDLCMD_OFS_DEVHEAD: begin
                rd_val = {24'h000000, s.devhead};
            end
            `IDLCMD_OFS_STATUS: begin
                // df, drq, cor, idx always zero
                rd_val = {24'h000000, bsy, !bsy, 1'b0, s.sync2, 3'h0, s.err_abt}; // RQ17
            end
            `IDLCMD_OFS_ERROR: begin
                rd_val = {29'h00000000, s.err_abt, 2'h0}; // RQ17
            end
            `IDLCMD_OFS_GEOM: begin
                // upper half sectors per track, lower half head count
                rd_val = {8'h00, s.spt, 11'h000, heads}; // RQ12
            end
            `IDLCMD_OFS_CTRL: begin
                rd_val = {30'h00000000, s.revert_en, 1'b0};
            end
            `IDLCMD_OFS_IRQ_STAT: begin
                rd_val = {29'h00000000, s.irq_stat};
            end
            `IDLCMD_OFS_IRQ_MASK: begin
                rd_val = {29'h00000000, s.irq_mask};
            end
            `IDLCMD_OFS_PMODE: begin
                rd_val = {28'h0000000, s.spin_up, s.t_apd, s.standby, s.idle};
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    endfunction

    always_comb begin
        logic acc;
        logic wr_cmd;
        logic [7:0] op;
        logic [2:0] ev;
        logic [2:0] clr;
        acc = 1'b0;
        wr_cmd = 1'b0;
        op = 8'h00;
        ev = 3'h0;
        clr = 3'h0;
        s_nxt = s_r;
        s_nxt.t_load = 1'b0;
        s_nxt.t_access = 1'b0;

        // two flops before the speed indication is used
        s_nxt.sync1 = spindle_at_speed;
        s_nxt.sync2 = s_r.sync1;

        // read data phase: one wait state so a preceding write is seen
        if (s_r.ph_rd) begin
            s_nxt.hrdata = rd_val(s_r, s_r.ph_addr);
            s_nxt.hready = 1'b1;
            s_nxt.ph_rd = 1'b0;
            if (s_r.ph_addr == `IDLCMD_OFS_IRQ_STAT) begin
                clr = s_r.irq_stat;
            end
        end

        // write data phase
        if (s_r.ph_wr) begin
            s_nxt.ph_wr = 1'b0;
            case (s_r.ph_addr)
                `IDLCMD_OFS_CMD: begin
                    wr_cmd = (s_r.cs == idlcmd_pkg::CS_READY);
                    op = hwdata[7:0];
                end
                `IDLCMD_OFS_SECCNT: begin
                    if (s_r.cs == idlcmd_pkg::CS_READY) begin
                        s_nxt.seccnt = hwdata[7:0];
                    end
                end
                `IDLCMD_OFS_DEVHEAD: begin
                    if (s_r.cs == idlcmd_pkg::CS_READY) begin
                        s_nxt.devhead = hwdata[7:0];
                    end
                end
                `IDLCMD_OFS_CTRL: begin
                    s_nxt.revert_en = hwdata[`IDLCMD_CTRL_REVERT];
                    if (hwdata[`IDLCMD_CTRL_SRST]) begin
                        s_nxt.err_abt = 1'b0;
                        if (s_r.revert_en) begin
                            s_nxt.spt = `IDLCMD_RST_SPT; // RQ13
                            s_nxt.heads_m1 = `IDLCMD_RST_HEADS_M1; // RQ13
                        end
                    end
                end
                `IDLCMD_OFS_IRQ_MASK: begin
                    s_nxt.irq_mask = hwdata[2:0];
                end
                default: begin
                    s_nxt.ph_wr = 1'b0;
                end
            endcase
        end

        // address phase; non-word writes are dropped
        acc = hsel && htrans[1] && hready;
        if (acc) begin
            s_nxt.t_access = 1'b1; // RQ7
            s_nxt.ph_addr = haddr[7:2];
            if (hwrite) begin
                s_nxt.ph_wr = (hsize == `IDLCMD_HSIZE_WORD);
            end else begin
                s_nxt.ph_rd = 1'b1;
                s_nxt.hready = 1'b0;
            end
        end

        // command execution
        case (s_r.cs)
            idlcmd_pkg::CS_READY: begin
                if (wr_cmd) begin
                    s_nxt.err_abt = 1'b0; // RQ17
                    if ((op == `IDLCMD_OP_IDLE_A) || (op == `IDLCMD_OP_IDLE_B) ||
                        (op == `IDLCMD_OP_IMM_A) || (op == `IDLCMD_OP_IMM_B)) begin
                        if (((op == `IDLCMD_OP_IDLE_A) || (op == `IDLCMD_OP_IDLE_B)) &&
                            dec_abort) begin
                            s_nxt.err_abt = 1'b1; // RQ5
                            ev[`IDLCMD_EV_ABORT] = 1'b1;
                            ev[`IDLCMD_EV_DONE] = 1'b1;
                        end else begin
                            if ((op == `IDLCMD_OP_IDLE_A) || (op == `IDLCMD_OP_IDLE_B)) begin
                                // load supersedes the access reload of this write
                                s_nxt.t_load = 1'b1; // RQ1
                                s_nxt.t_secs = dec_secs; // RQ4
                                s_nxt.t_apd = dec_apd; // RQ3
                            end
                            // immediate form leaves the timer programming alone
                            s_nxt.idle = 1'b1; // RQ9 RQ10
                            s_nxt.standby = 1'b0; // RQ1
                            if (!s_r.sync2) begin
                                s_nxt.spin_up = 1'b1; // RQ2
                                s_nxt.cs = idlcmd_pkg::CS_SPIN;
                            end else begin
                                ev[`IDLCMD_EV_DONE] = 1'b1; // RQ8
                            end
                        end
                    end else if (op == `IDLCMD_OP_INIT) begin
                        // zero is kept as zero sectors per track
                        s_nxt.spt = s_r.seccnt; // RQ11 RQ14
                        s_nxt.heads_m1 = s_r.devhead[3:0]; // RQ11 RQ15
                        ev[`IDLCMD_EV_DONE] = 1'b1;
                    end else begin
                        s_nxt.err_abt = 1'b1; // RQ17
                        ev[`IDLCMD_EV_ABORT] = 1'b1;
                        ev[`IDLCMD_EV_DONE] = 1'b1;
                    end
                end
            end
            idlcmd_pkg::CS_SPIN: begin
                if (s_r.sync2) begin
                    s_nxt.spin_up = 1'b0;
                    s_nxt.cs = idlcmd_pkg::CS_READY; // RQ17
                    ev[`IDLCMD_EV_DONE] = 1'b1;
                end
            end
            default: begin
                s_nxt.cs = idlcmd_pkg::CS_READY;
            end
        endcase

        // automatic power-down
        if (tif.expired && !s_nxt.t_load) begin
            s_nxt.idle = 1'b0; // RQ6
            s_nxt.standby = 1'b1; // RQ6
            ev[`IDLCMD_EV_STBY] = 1'b1;
        end

        // a new event wins over the read that clears it
        s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.hready <= 1'b1;
            s_r.cs <= idlcmd_pkg::CS_READY;
            s_r.spt <= `IDLCMD_RST_SPT;
            s_r.heads_m1 <= `IDLCMD_RST_HEADS_M1;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* tb/idlcmd_props.sv */
/*
 assertions on the ports of idlcmd_top.
 assumes hready is tied to hreadyout and one clock domain.
*/
`timescale 1ns/10ps
`include "idlcmd_consts.svh"
module idlcmd_props #(
    parameter int unsigned TICK_CYC = 10
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // spindle and state
    input wire logic spindle_at_speed,
    input wire logic spin_up_req,
    input wire logic idle_mode,
    input wire logic standby_mode,
    input wire logic irq
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic take;
    assign take = hsel && htrans[1] && hready;
    // busy refuses commands, so only idle-ready cases are judged
    sequence imm_cmd;
        take && hwrite && hsize == `IDLCMD_HSIZE_WORD && haddr[7:2] == `IDLCMD_OFS_CMD
        && !spin_up_req ##1 (hwdata[7:0] == `IDLCMD_OP_IMM_A || hwdata[7:0] == `IDLCMD_OP_IMM_B);
    endsequence
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_imm_idle: assert property (imm_cmd |-> ##[1:2] (idle_mode && !standby_mode))
        else $error("idle immediate not entering idle");
    chk_standby_excl: assert property (standby_mode |-> !idle_mode)
        else $error("standby and idle together");
    chk_standby_entry: assert property ($rose(standby_mode) |-> $fell(idle_mode))
        else $error("standby not entered from idle");
    chk_spin_skip: assert property (spindle_at_speed && $past(spindle_at_speed)
        && $past(spindle_at_speed, 2) && $past(spindle_at_speed, 3) && $past(spindle_at_speed, 4)
        && $past(spindle_at_speed, 5) |-> !$rose(spin_up_req))
        else $error("spin-up while turning");
    chk_spin_release: assert property (spin_up_req && $rose(spindle_at_speed)
        |-> ##[1:4] !spin_up_req)
        else $error("spin-up request kept at speed");
    chk_spin_hold: assert property (spin_up_req && !spindle_at_speed
        && !$past(spindle_at_speed) && !$past(spindle_at_speed, 2)
        && !$past(spindle_at_speed, 3) |=> spin_up_req)
        else $error("spin-up dropped before speed");
    cover property ($rose(standby_mode));
    cover property ($rose(spin_up_req));
    cover property ($rose(irq));
endmodule

bind idlcmd_top idlcmd_props #(.TICK_CYC(TICK_CYC)) idlcmd_props_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .spindle_at_speed(spindle_at_speed),
    .spin_up_req(spin_up_req), .idle_mode(idle_mode), .standby_mode(standby_mode),
    .irq(irq));

/* tb/idlcmd_spindle.sv */
/*
 spindle motor stand-in: reaches speed lag + 1 cycles into a spin-up
 request; assumes the bench drives lag and stop.
*/
`timescale 1ns/10ps
module idlcmd_spindle (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic spin_up_req,
    input wire logic stop,
    input wire logic [7:0] lag,
    // speed indication
    output logic at_speed
);
    logic [7:0] cnt_r;
    // a stopped motor never reports speed, even mid-request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 8'h00;
            at_speed <= 1'b0;
        end else if (stop) begin
            cnt_r <= 8'h00;
            at_speed <= 1'b0;
        end else if (spin_up_req && !at_speed) begin
            cnt_r <= cnt_r + 8'h01;
            at_speed <= (cnt_r >= lag);
        end
    end
endmodule

/* tb/tb_idlcmd_top.sv */
/*
 self-checking bench for idlcmd_top with a spindle stand-in;
 assumes a short timer tick through TICK_CYC.
*/
`timescale 1ns/10ps
`include "idlcmd_consts.svh"
module tb_idlcmd_top;
    localparam int unsigned TICK = 10;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, spin_up_req, idle_mode, standby_mode, irq, at_speed;
    logic [31:0] hrdata, rd;
    logic stop = 1'b0;
    logic [7:0] lag = 8'h14;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 hclk = ~hclk;
    idlcmd_top #(.TICK_CYC(TICK)) idlcmd_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .spindle_at_speed(at_speed), .spin_up_req(spin_up_req), .idle_mode(idle_mode),
        .standby_mode(standby_mode), .irq(irq));
    idlcmd_spindle idlcmd_spindle_i (.hclk(hclk), .hresetn(hresetn),
        .spin_up_req(spin_up_req), .stop(stop), .lag(lag), .at_speed(at_speed));
    task automatic print_verdict;
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 95000) begin
            chk("timeout", 32'h1, 32'h0);
            print_verdict;
        end
    end
    // single word transfer; waits on hready, no fixed latency assumed
    task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0);
        chk(what, rd, exp);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge hclk);
            n++;
        end
    endtask
    // counts cycles to standby; any bus access here would rearm the timer
    task automatic wait_sb(input int exp);
        int n;
        n = 0;
        @(posedge hclk);
        while (standby_mode !== 1'b1 && n < exp + 20) begin
            @(posedge hclk);
            n++;
        end
        chk("standby delay", 32'(n >= exp - 4 && n <= exp + 4), 32'h1);
    endtask
    task automatic t_reset;
        rchk("pmode", `IDLCMD_OFS_PMODE, 32'h0);
        rchk("geom", `IDLCMD_OFS_GEOM, 32'h003f0010);
        rchk("unmapped", 6'h0f, 32'h0);
    endtask
    task automatic t_geom;
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'h0);
        ahb(1'b1, `IDLCMD_OFS_DEVHEAD, 32'ha5);
        ahb(1'b1, `IDLCMD_OFS_CMD, 32'h91);
        rchk("geom", `IDLCMD_OFS_GEOM, 32'h00000006);
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'h20);
        ahb(1'b1, `IDLCMD_OFS_DEVHEAD, 32'h0f);
        ahb(1'b1, `IDLCMD_OFS_CMD, 32'h91);
        ahb(1'b1, `IDLCMD_OFS_CTRL, 32'h1);
        rchk("geom", `IDLCMD_OFS_GEOM, 32'h00200010);
        ahb(1'b1, `IDLCMD_OFS_CTRL, 32'h2);
        ahb(1'b1, `IDLCMD_OFS_CTRL, 32'h3);
        rchk("geom", `IDLCMD_OFS_GEOM, 32'h003f0010);
        ahb(1'b1, `IDLCMD_OFS_CTRL, 32'h0);
    endtask
    task automatic t_spin;
        ahb(1'b1, `IDLCMD_OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 2; i++) begin
            lag <= (i == 0) ? 8'h14 : 8'h01;
            stop <= 1'b1;
            repeat (2) @(posedge hclk);
            stop <= 1'b0;
            repeat (3) @(posedge hclk);
            ahb(1'b0, `IDLCMD_OFS_IRQ_STAT, 32'h0);
            ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IMM_A});
            repeat (2) @(posedge hclk);
            chk("spin request", spin_up_req, 1'b1);
            wait_irq;
            chk("done irq", irq, 1'b1);
            chk("spin request", spin_up_req, 1'b0);
            ahb(1'b0, `IDLCMD_OFS_STATUS, 32'h0);
            chk("status", rd & 32'ha1, 32'h0);
            rchk("irq stat", `IDLCMD_OFS_IRQ_STAT, 32'h1);
        end
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IMM_B});
        repeat (4) @(posedge hclk);
        chk("spin request", spin_up_req, 1'b0);
        chk("done irq", irq, 1'b1);
        rchk("pmode", `IDLCMD_OFS_PMODE, 32'h1);
    endtask
    task automatic t_abort;
        ahb(1'b1, `IDLCMD_OFS_IRQ_MASK, 32'h0);
        ahb(1'b0, `IDLCMD_OFS_IRQ_STAT, 32'h0);
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'hfe);
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IDLE_A});
        repeat (3) @(posedge hclk);
        chk("masked irq", irq, 1'b0);
        rchk("error", `IDLCMD_OFS_ERROR, 32'h4);
        ahb(1'b0, `IDLCMD_OFS_STATUS, 32'h0);
        chk("status", rd & 32'ha1, 32'h1);
        rchk("pmode", `IDLCMD_OFS_PMODE, 32'h1);
        ahb(1'b1, `IDLCMD_OFS_IRQ_MASK, 32'h4);
        repeat (2) @(posedge hclk);
        chk("abort irq", irq, 1'b1);
        rchk("irq stat", `IDLCMD_OFS_IRQ_STAT, 32'h5);
        repeat (2) @(posedge hclk);
        chk("cleared irq", irq, 1'b0);
    endtask
    task automatic t_zero;
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'h0);
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IDLE_B});
        repeat (200) @(posedge hclk);
        chk("standby", standby_mode, 1'b0);
        chk("idle", idle_mode, 1'b1);
        rchk("pmode", `IDLCMD_OFS_PMODE, 32'h1);
        rchk("error", `IDLCMD_OFS_ERROR, 32'h0);
        ahb(1'b1, `IDLCMD_OFS_CMD, 32'h0);
        rchk("error", `IDLCMD_OFS_ERROR, 32'h4);
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'hfd);
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IDLE_A});
        rchk("pmode", `IDLCMD_OFS_PMODE, 32'h5);
    endtask
    // code and its interval in seconds, worked from the decode rules
    task automatic t_timer;
        logic [7:0] codes [5] = '{8'd1, 8'd240, 8'd241, 8'd252, 8'd255};
        int secs [5] = '{5, 1200, 1800, 1260, 1275};
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, `IDLCMD_OFS_SECCNT, {24'h0, codes[i]});
            ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IDLE_A});
            wait_sb(secs[i] * TICK);
        end
        ahb(1'b0, `IDLCMD_OFS_PMODE, 32'h0);
        chk("pmode", rd & 32'h3, 32'h2);
    endtask
    task automatic t_reload;
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'h2);
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IDLE_A});
        repeat (70) @(posedge hclk);
        rchk("seccnt", `IDLCMD_OFS_SECCNT, 32'h2);
        wait_sb(10 * TICK);
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'h1);
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IDLE_B});
        ahb(1'b1, `IDLCMD_OFS_SECCNT, 32'h0);
        ahb(1'b1, `IDLCMD_OFS_CMD, {24'h0, `IDLCMD_OP_IMM_A});
        wait_sb(5 * TICK);
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_geom;
        t_spin;
        t_abort;
        t_zero;
        t_timer;
        t_reload;
        print_verdict;
    end
endmodule
